// File: logic/spff_defines.vh
// Behaviour
// - The fault flag register sits at index 0x2F, is eight bits wide and reads zero after reset.
// - Bit 7 latches an undervoltage fault of the second converter and clears on entry into the initialization state when its undervoltage mask bit is one.
// - Bit 6 latches a negative overcurrent fault of the second converter.
// - Bit 5 latches a positive overcurrent fault of the second converter.
// - Bit 4 latches a short to ground of the second converter.
// - Bit 3 latches an undervoltage fault of the first converter and clears on entry into the initialization state when its undervoltage mask bit is one.
// - Bit 2 latches a negative overcurrent fault of the first converter.
// - Bit 1 latches a positive overcurrent fault of the first converter.
// - Bit 0 latches a short to ground of the first converter.
// - A flag reads one after a fault and zero otherwise; writing one clears it unless its fault is still present, and writing zero leaves it.
`ifndef SPFF_DEFINES_VH
`define SPFF_DEFINES_VH

// Register indices; the byte address is four times the index.
`define SPFF_IDX_FLAGS 6'h2F
`define SPFF_IDX_UNDERVOLT_MASK_BIT 6'h38
`define SPFF_IDX_INT_STATUS 6'h39
`define SPFF_IDX_INT_MASK 6'h3A
`define SPFF_IDX_LIVE 6'h3B
`define SPFF_ADDR_FLAGS {`SPFF_IDX_FLAGS, 2'b00}
`define SPFF_ADDR_UNDERVOLT_MASK_BIT {`SPFF_IDX_UNDERVOLT_MASK_BIT, 2'b00}
`define SPFF_ADDR_INT_STATUS {`SPFF_IDX_INT_STATUS, 2'b00}
`define SPFF_ADDR_INT_MASK {`SPFF_IDX_INT_MASK, 2'b00}
`define SPFF_ADDR_LIVE {`SPFF_IDX_LIVE, 2'b00}

// Field positions of the fault flag register.
`define SPFF_BIT_B_UV 7
`define SPFF_BIT_B_NEG_OC 6
`define SPFF_BIT_B_POS_OC 5
`define SPFF_BIT_B_SCG 4
`define SPFF_BIT_A_UV 3
`define SPFF_BIT_A_NEG_OC 2
`define SPFF_BIT_A_POS_OC 1
`define SPFF_BIT_A_SCG 0

// Undervoltage positions only; the mask register shares the flag layout.
`define SPFF_UV_BITS 8'h88

// Reset values.
`define SPFF_RST_FLAGS 8'h00
`define SPFF_RST_UNDERVOLT_MASK_BIT 8'h00
`define SPFF_RST_INT_STATUS 8'h00
`define SPFF_RST_INT_MASK 8'h00

// Widths and synchroniser depth.
`define SPFF_REG_W 8
`define SPFF_ADDR_W 8
`define SPFF_SYNC_STAGES 2

`endif

// File: logic/spff_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser, one per bit, for the asynchronous fault comparators.
module spff_sync #(
   parameter W = 8
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Data
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg meta_reg;
         reg stable_reg;
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_reg <= 1'b0;
               stable_reg <= 1'b0;
            end
            else
            begin
               meta_reg <= async_in[i];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stable_reg;
      end
   endgenerate

endmodule // spff_sync

// File: logic/spff_sticky.v
`timescale 1ns/1ps
// Sticky bit vector: a set beats a clear landing in the same cycle.
module spff_sticky #(
   parameter W = 8,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Set and clear requests
   input wire [W-1:0] set_vec,
   input wire [W-1:0] clr_vec,
   // State
   output wire [W-1:0] q
);

   reg [W-1:0] bits_reg;
   wire [W-1:0] bits_next;

   assign bits_next = set_vec | (bits_reg & ~clr_vec);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bits_reg <= RST;
      else
         bits_reg <= bits_next;
   end

   assign q = bits_reg;

endmodule // spff_sticky

// File: logic/spff_fault_flags.v
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "spff_defines.vh"
module spff_fault_flags (
   // Clock and reset
   input wire pclk,
   input wire presetn,

   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SPFF_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,

   // Fault comparators of the first converter, asynchronous levels
   input wire conv_a_undervolt_in,
   input wire conv_a_neg_overcurrent_in,
   input wire conv_a_pos_overcurrent_in,
   input wire conv_a_ground_short_in,

   // Fault comparators of the second converter, asynchronous levels
   input wire conv_b_undervolt_in,
   input wire conv_b_neg_overcurrent_in,
   input wire conv_b_pos_overcurrent_in,
   input wire conv_b_ground_short_in,

   // Sequencer state, same clock domain
   input wire initialization_state,

   // Flag state for the rest of the device
   output wire [`SPFF_REG_W-1:0] fault_flags,

   // Interrupt
   output wire irq
);

   // Raw and synchronised fault levels, arranged in the flag layout.
   wire [`SPFF_REG_W-1:0] fault_raw;
   wire [`SPFF_REG_W-1:0] fault_sync;

   // Flag register state and its update terms.
   wire [`SPFF_REG_W-1:0] flags_q;
   wire [`SPFF_REG_W-1:0] flags_set;
   wire [`SPFF_REG_W-1:0] flags_clr;
   wire [`SPFF_REG_W-1:0] flags_w1c;
   wire [`SPFF_REG_W-1:0] flags_auto_clr;

   // Software registers of this block.
   reg [`SPFF_REG_W-1:0] undervolt_mask_bit_reg;
   reg [`SPFF_REG_W-1:0] undervolt_mask_bit_next;
   reg [`SPFF_REG_W-1:0] int_mask_reg;
   reg [`SPFF_REG_W-1:0] int_mask_next;

   // Interrupt status state and its update terms.
   wire [`SPFF_REG_W-1:0] int_status_q;
   wire [`SPFF_REG_W-1:0] int_status_set;
   wire [`SPFF_REG_W-1:0] int_status_clr;

   // Initialization entry detection.
   reg init_prev_reg;
   wire init_entry;

   // Bus decode.
   wire setup_phase;
   wire access_phase;
   wire wr_access;
   wire rd_access;
   wire lane0_wr;
   wire hit_flags;
   wire hit_undervolt_mask_bit;
   wire hit_int_status;
   wire hit_int_mask;
   wire hit_live;
   wire addr_mapped;
   reg [31:0] rd_mux;
   reg [31:0] prdata_next;

   // Bits of the status register that were returned by the pending read.
   reg [`SPFF_REG_W-1:0] rd_status_snap_reg;
   reg [`SPFF_REG_W-1:0] rd_status_snap_next;

   assign fault_raw[`SPFF_BIT_B_UV] = conv_b_undervolt_in;
   assign fault_raw[`SPFF_BIT_B_NEG_OC] = conv_b_neg_overcurrent_in;
   assign fault_raw[`SPFF_BIT_B_POS_OC] = conv_b_pos_overcurrent_in;
   assign fault_raw[`SPFF_BIT_B_SCG] = conv_b_ground_short_in;
   assign fault_raw[`SPFF_BIT_A_UV] = conv_a_undervolt_in;
   assign fault_raw[`SPFF_BIT_A_NEG_OC] = conv_a_neg_overcurrent_in;
   assign fault_raw[`SPFF_BIT_A_POS_OC] = conv_a_pos_overcurrent_in;
   assign fault_raw[`SPFF_BIT_A_SCG] = conv_a_ground_short_in;

   // The comparators are analog and unrelated to pclk.
   spff_sync #(
      .W(`SPFF_REG_W)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(fault_raw),
      .sync_out(fault_sync)
   );

   // Bus phases. The slave never inserts wait states.
   assign pready = 1'b1;
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access = access_phase & pwrite;
   assign rd_access = access_phase & ~pwrite;
   assign lane0_wr = wr_access & pstrb[0];

   assign hit_flags = (paddr == `SPFF_ADDR_FLAGS);
   assign hit_undervolt_mask_bit = (paddr == `SPFF_ADDR_UNDERVOLT_MASK_BIT);
   assign hit_int_status = (paddr == `SPFF_ADDR_INT_STATUS);
   assign hit_int_mask = (paddr == `SPFF_ADDR_INT_MASK);
   assign hit_live = (paddr == `SPFF_ADDR_LIVE);
   assign addr_mapped = hit_flags | hit_undervolt_mask_bit | hit_int_status | hit_int_mask | hit_live;

   // Unmapped or misaligned addresses answer with an error and change nothing.
   assign pslverr = access_phase & ~addr_mapped;

   // Each comparator level, while present, asks its own flag to be set.
   assign flags_set = fault_sync;

   // Ones written clear their flags, zeros are ignored.
   assign flags_w1c = (lane0_wr & hit_flags) ? pwdata[`SPFF_REG_W-1:0] : `SPFF_RST_FLAGS;

   // Only on the edge into initialization, never while it merely lasts.
   assign init_entry = initialization_state & ~init_prev_reg;

   // Undervoltage flags clear on that edge where their mask bit is one.
   assign flags_auto_clr = init_entry ? (undervolt_mask_bit_reg & `SPFF_UV_BITS) : `SPFF_RST_FLAGS;

   assign flags_clr = flags_w1c | flags_auto_clr;

   spff_sticky #(
      .W(`SPFF_REG_W),
      .RST(`SPFF_RST_FLAGS)
   ) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set_vec(flags_set),
      .clr_vec(flags_clr),
      .q(flags_q)
   );

   assign fault_flags = flags_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         init_prev_reg <= 1'b0;
      else
         init_prev_reg <= initialization_state;
   end

   // A flag that goes from clear to set raises its interrupt event.
   assign int_status_set = flags_set & ~flags_q;

   // A read clears only the bits it returned, so a later event survives.
   assign int_status_clr = (rd_access & hit_int_status) ? rd_status_snap_reg : `SPFF_RST_INT_STATUS;

   spff_sticky #(
      .W(`SPFF_REG_W),
      .RST(`SPFF_RST_INT_STATUS)
   ) u_int_status (
      .pclk(pclk),
      .presetn(presetn),
      .set_vec(int_status_set),
      .clr_vec(int_status_clr),
      .q(int_status_q)
   );

   assign irq = |(int_status_q & int_mask_reg);

   always @*
   begin
      undervolt_mask_bit_next = undervolt_mask_bit_reg;
      if (lane0_wr & hit_undervolt_mask_bit)
         undervolt_mask_bit_next = pwdata[`SPFF_REG_W-1:0] & `SPFF_UV_BITS;
   end

   always @*
   begin
      int_mask_next = int_mask_reg;
      if (lane0_wr & hit_int_mask)
         int_mask_next = pwdata[`SPFF_REG_W-1:0];
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         undervolt_mask_bit_reg <= `SPFF_RST_UNDERVOLT_MASK_BIT;
         int_mask_reg <= `SPFF_RST_INT_MASK;
      end
      else
      begin
         undervolt_mask_bit_reg <= undervolt_mask_bit_next;
         int_mask_reg <= int_mask_next;
      end
   end

   // Read data for the addressed register; bits above the byte read zero.
   always @*
   begin
      rd_mux = 32'h00000000;
      case (1'b1)
         hit_flags:
            rd_mux[`SPFF_REG_W-1:0] = flags_q;
         hit_undervolt_mask_bit:
            rd_mux[`SPFF_REG_W-1:0] = undervolt_mask_bit_reg;
         hit_int_status:
            rd_mux[`SPFF_REG_W-1:0] = int_status_q;
         hit_int_mask:
            rd_mux[`SPFF_REG_W-1:0] = int_mask_reg;
         hit_live:
            rd_mux[`SPFF_REG_W-1:0] = fault_sync;
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // Read data is captured in the setup cycle and held through the access.
   always @*
   begin
      prdata_next = prdata;
      rd_status_snap_next = rd_status_snap_reg;
      if (setup_phase & ~pwrite)
      begin
         prdata_next = rd_mux;
         rd_status_snap_next = hit_int_status ? int_status_q : `SPFF_RST_INT_STATUS;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         rd_status_snap_reg <= `SPFF_RST_INT_STATUS;
      end
      else
      begin
         prdata <= prdata_next;
         rd_status_snap_reg <= rd_status_snap_next;
      end
   end

endmodule // spff_fault_flags

// File: sim/spff_chk.sv
`timescale 1ns/1ps
`include "spff_defines.vh"
module spff_chk (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pslverr,
   // Faults, sequencer and flags
   input wire conv_a_undervolt_in,
   input wire conv_a_neg_overcurrent_in,
   input wire conv_a_pos_overcurrent_in,
   input wire conv_a_ground_short_in,
   input wire conv_b_undervolt_in,
   input wire conv_b_neg_overcurrent_in,
   input wire conv_b_pos_overcurrent_in,
   input wire conv_b_ground_short_in,
   input wire initialization_state,
   input wire [7:0] fault_flags
);
   wire [7:0] flt = {conv_b_undervolt_in, conv_b_neg_overcurrent_in, conv_b_pos_overcurrent_in,
      conv_b_ground_short_in, conv_a_undervolt_in, conv_a_neg_overcurrent_in,
      conv_a_pos_overcurrent_in, conv_a_ground_short_in};
   wire [7:0] wlo = pwdata[7:0];
   wire acc = psel & penable;
   wire hit = paddr == `SPFF_ADDR_FLAGS;
   wire mapped = hit | paddr == `SPFF_ADDR_UNDERVOLT_MASK_BIT | paddr == `SPFF_ADDR_INT_STATUS |
      paddr == `SPFF_ADDR_INT_MASK | paddr == `SPFF_ADDR_LIVE;
   wire w1c = acc & pwrite & hit & pstrb[0];
   reg init_d;
   wire init_rise = initialization_state & ~init_d;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         init_d <= 1'b0;
      else
         init_d <= initialization_state;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_flags_reset: assert property ($rose(presetn) |-> fault_flags == 8'h00)
      else $error("flags not zero after reset");
   a_fault_sets: assert property (flt != 8'h00 |-> ##3 (fault_flags & $past(flt, 3)) == $past(flt, 3))
      else $error("fault did not set its flag");
   a_fall_cause: assert property (|($past(fault_flags) & ~fault_flags) |-> $past(w1c) || $past(init_rise))
      else $error("flag cleared without cause");
   a_clear_effect: assert property (w1c |=> (fault_flags & $past(wlo) & ~$past(flt, 3)) == 8'h00)
      else $error("write of one did not clear");
   a_set_wins: assert property (w1c |=> (fault_flags & $past(flt, 3)) == $past(flt, 3))
      else $error("clear beat a pending fault");
   a_rise_cause: assert property ((fault_flags & ~$past(fault_flags) & ~$past(flt, 3)) == 8'h00)
      else $error("flag set without fault");
   a_read_flags: assert property (acc && !pwrite && hit |-> prdata == {24'h000000, $past(fault_flags)})
      else $error("read data differs from flags");
   a_err_map: assert property (acc |-> pslverr == !mapped)
      else $error("error response wrong");
   a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
endmodule // spff_chk
bind spff_fault_flags spff_chk spff_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pslverr(pslverr), .conv_a_undervolt_in(conv_a_undervolt_in),
   .conv_a_neg_overcurrent_in(conv_a_neg_overcurrent_in),
   .conv_a_pos_overcurrent_in(conv_a_pos_overcurrent_in),
   .conv_a_ground_short_in(conv_a_ground_short_in), .conv_b_undervolt_in(conv_b_undervolt_in),
   .conv_b_neg_overcurrent_in(conv_b_neg_overcurrent_in),
   .conv_b_pos_overcurrent_in(conv_b_pos_overcurrent_in),
   .conv_b_ground_short_in(conv_b_ground_short_in),
   .initialization_state(initialization_state), .fault_flags(fault_flags));

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "spff_defines.vh"
module tb_top;
   reg pclk, presetn, psel, penable, pwrite, init, e;
   reg [7:0] paddr, flt, mf, ms, mk, v;
   reg [31:0] pwdata, r;
   reg [3:0] pstrb;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [7:0] fault_flags;
   integer bad_count, total_checks, seed, i;
   spff_fault_flags spff_fault_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_a_ground_short_in(flt[0]),
      .conv_a_pos_overcurrent_in(flt[1]), .conv_a_neg_overcurrent_in(flt[2]),
      .conv_a_undervolt_in(flt[3]), .conv_b_ground_short_in(flt[4]),
      .conv_b_pos_overcurrent_in(flt[5]), .conv_b_neg_overcurrent_in(flt[6]),
      .conv_b_undervolt_in(flt[7]), .initialization_state(init), .fault_flags(fault_flags),
      .irq(irq));
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task complete_run;
   begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   task chk(input [31:0] g, input [31:0] x, input string m);
   begin
      total_checks = total_checks + 1;
      if (g !== x)
      begin
         bad_count = bad_count + 1;
         $display("wrong value at %0t: %s", $time, m);
      end
   end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
   begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n == 20)
      begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end
   endtask
   task rd(input [7:0] a, input [7:0] x);
   begin
      apb(1'b0, a, 32'h00000000);
      chk(r, {24'h000000, x}, "read data");
      chk(e, 1'b0, "read error");
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      apb(1'b1, a, $random(seed) & 32'hFFFFFF00 | d);
   endtask
   task fault(input [7:0] f);
   begin
      flt <= f;
      @(posedge pclk);
      flt <= 8'h00;
      repeat (4) @(posedge pclk);
      ms = ms | (f & ~mf);
      mf = mf | f;
   end
   endtask
   initial
   begin
      seed = 32'hE2B6;
      {presetn, psel, penable, pwrite, init, paddr, flt, pwdata} = 0;
      pstrb = 4'hF;
      {bad_count, total_checks, mf, ms, mk} = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SPFF_ADDR_FLAGS, 8'h00);
      rd(`SPFF_ADDR_UNDERVOLT_MASK_BIT, 8'h00);
      rd(`SPFF_ADDR_INT_STATUS, 8'h00);
      $display("test reset done");
      for (i = 0; i < 8; i = i + 1)
      begin
         fault(8'h01 << i);
         rd(`SPFF_ADDR_FLAGS, mf);
      end
      wr(`SPFF_ADDR_FLAGS, 8'h00);
      rd(`SPFF_ADDR_FLAGS, mf);
      for (i = 0; i < 6; i = i + 1)
      begin
         v = $random(seed);
         wr(`SPFF_ADDR_FLAGS, v);
         mf = mf & ~v;
         rd(`SPFF_ADDR_FLAGS, mf);
         fault(v);
      end
      flt <= 8'h24;
      ms = ms | (8'h24 & ~mf);
      mf = mf | 8'h24;
      repeat (4) @(posedge pclk);
      wr(`SPFF_ADDR_FLAGS, 8'hFF);
      rd(`SPFF_ADDR_FLAGS, 8'h24);
      flt <= 8'h00;
      repeat (4) @(posedge pclk);
      wr(`SPFF_ADDR_FLAGS, 8'hFF);
      mf = 8'h00;
      rd(`SPFF_ADDR_FLAGS, mf);
      $display("test flags done");
      fault(8'hFF);
      init <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(`SPFF_ADDR_FLAGS, mf);
      init <= 1'b0;
      wr(`SPFF_ADDR_UNDERVOLT_MASK_BIT, 8'hFF);
      rd(`SPFF_ADDR_UNDERVOLT_MASK_BIT, 8'h88);
      init <= 1'b1;
      repeat (2) @(posedge pclk);
      mf = 8'h77;
      rd(`SPFF_ADDR_FLAGS, mf);
      fault(8'h88);
      rd(`SPFF_ADDR_FLAGS, mf);
      init <= 1'b0;
      $display("test init done");
      rd(`SPFF_ADDR_INT_STATUS, ms);
      ms = 8'h00;
      wr(`SPFF_ADDR_FLAGS, 8'hFF);
      mf = 8'h00;
      wr(`SPFF_ADDR_INT_MASK, 8'h01);
      mk = 8'h01;
      fault(8'h03);
      @(negedge pclk);
      chk(irq, |(ms & mk), "irq raised");
      rd(`SPFF_ADDR_INT_STATUS, ms);
      ms = 8'h00;
      @(negedge pclk);
      chk(irq, 1'b0, "irq cleared");
      wr(`SPFF_ADDR_INT_MASK, 8'h00);
      fault(8'h10);
      @(negedge pclk);
      chk(irq, 1'b0, "irq masked");
      $display("test interrupt done");
      rd(`SPFF_ADDR_INT_MASK, 8'h00);
      rd(`SPFF_ADDR_LIVE, 8'h00);
      pstrb <= 4'hE;
      wr(`SPFF_ADDR_FLAGS, 8'hFF);
      pstrb <= 4'hF;
      rd(`SPFF_ADDR_FLAGS, mf);
      apb(1'b0, 8'h00, 32'h00000000);
      chk(e, 1'b1, "unmapped error");
      apb(1'b1, 8'hBD, 32'h000000FF);
      chk(e, 1'b1, "misaligned error");
      rd(`SPFF_ADDR_FLAGS, mf);
      $display("test address done");
      complete_run;
   end
endmodule // tb_top
